// [bench/tach_source.sv]
// tachometer source model: raw pulse of requested length
`timescale 1ns/1ns
module tach_source (
  input wire logic mclk,
  input wire logic fire,
  input wire logic [3:0] width,
  output logic tach_out
);
  logic [3:0] left_reg = 4'h0;

  // load the pulse length on request, count it down; any length is legal
  always @(posedge mclk) begin
    if (fire) begin
      left_reg <= width;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end

  // line rests low between pulses
  assign tach_out = (left_reg != 4'h0);
endmodule : tach_source

// [bench/tape_elapsed_time_updown_counter_test.sv]
// self-checking testbench for the tape elapsed time counter
`timescale 1ns/1ns
module tape_elapsed_time_updown_counter_test;
  import tape_timer_pkg::*;
  logic mclk, rst_n, tach, tape_direction_command, timer_clear_n, tape_abort_n, fire;
  logic [1:0] speed, bresp, rresp, rsp;
  logic [3:0] digit_out, pulse_len, wstrb;
  logic [7:0] slot_out, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, lfsr_state;
  int failures, comparisons, cycles;
  int digs[8];

  tach_source src (.mclk(mclk), .fire(fire), .width(pulse_len), .tach_out(tach));
  tape_timer dut (.mclk(mclk), .rst_n(rst_n), .tach_pulse_in(tach),
    .tape_direction_command(tape_direction_command), .speed_select_lo(speed[0]),
    .speed_select_hi(speed[1]), .timer_clear_n(timer_clear_n), .tape_abort_n(tape_abort_n),
    .digit_out(digit_out), .slot_out(slot_out), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of the digit ring
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction : rnd

  function automatic int modulus(input int k);
    return (k == 0) ? (8 >> int'(speed)) : (k == 3 || k == 5) ? 6 : 10;
  endfunction : modulus

  // one count step, top digit never takes a carry
  function automatic void model_step(input bit up);
    bit c;
    c = 1'b1;
    for (int k = 0; k < NUM_DIGITS - 1 && c; k++) begin
      if (up) begin
        digs[k]++;
        c = (digs[k] == modulus(k));
        if (c) digs[k] = 0;
      end else begin
        c = (digs[k] == 0);
        digs[k] = c ? modulus(k) - 1 : digs[k] - 1;
      end
    end
  endfunction : model_step

  function automatic logic [31:0] model_word();
    logic [31:0] w;
    w = 32'h0;
    for (int k = 0; k < 8; k++) w |= 32'(digs[k]) << (4 * k);
    return w;
  endfunction : model_word

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and bus tasks
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    report({30'h0, got}, {30'h0, exp});
  endtask : chk_resp

  task automatic chk_digit(input logic [3:0] got, input logic [3:0] exp);
    report({28'h0, got}, {28'h0, exp});
  endtask : chk_digit

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_cycles

  // entered just after a rising edge; handshakes judged from pre-edge values
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_read

  // one raw tach pulse of random length, then let the ring settle
  task automatic tach_step(input bit counts, input bit up);
    tape_direction_command <= up;
    pulse_len <= 4'(rnd() % 32'd7) + 4'h1;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    wait_cycles(40);
    if (counts) model_step(up);
  endtask : tach_step

  // compare snapshot register and one full turn of the digit ring
  task automatic check_all();
    logic [7:0] s;
    int k;
    axi_read(REG_COUNT, rd, rsp);
    chk_word(rd, model_word());
    @(negedge mclk);
    s = slot_out;
    repeat (8) begin
      k = 0;
      for (int j = 0; j < 8; j++) if (s[j]) k = j;
      chk_digit(digit_out, 4'(digs[k]));
      @(negedge mclk);
      chk_word({24'h0, slot_out}, {24'h0, s[6:0], s[7]});
      s = slot_out;
    end
    @(posedge mclk);
  endtask : check_all

  task automatic hw_clear();
    timer_clear_n <= 1'b0;
    tach_step(1'b0, 1'b1);
    timer_clear_n <= 1'b1;
    wait_cycles(10);
    digs = '{default: 0};
  endtask : hw_clear

  task give_verdict;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0; fire = 1'b0; pulse_len = 4'h1; tape_direction_command = 1'b1;
    speed = 2'h0; timer_clear_n = 1'b1; tape_abort_n = 1'b1; wstrb = 4'hf;
    awvalid = 1'b0; awaddr = 8'h0; wvalid = 1'b0; wdata = 32'h0; bready = 1'b0;
    arvalid = 1'b0; araddr = 8'h0; rready = 1'b0; failures = 0; comparisons = 0;
    cycles = 0; lfsr_state = 32'd85695; digs = '{default: 0};
    repeat (2) @(posedge mclk);
    #1 chk_word({24'h0, slot_out}, 32'h1);
    @(posedge mclk);
    rst_n <= 1'b1;
    tach_step(1'b0, 1'b1);
    check_all();
    axi_read(8'h0c, rd, rsp);
    chk_resp(rsp, RESP_SLVERR);
    chk_word(rd, 32'h0);
    axi_write(REG_COUNT, 32'hffffffff, rsp);
    chk_resp(rsp, RESP_OKAY);
    // every speed: wrap the prescaler into tenths
    for (int sp = 0; sp < 4; sp++) begin
      speed <= 2'(sp);
      hw_clear();
      repeat ((8 >> sp) + 1) begin
        tach_step(1'b1, 1'b1);
        check_all();
      end
    end
    axi_read(REG_STATUS, rd, rsp);
    chk_word(rd & 32'h1, 32'h1);
    wait_cycles(40);
    check_all();
    tape_abort_n <= 1'b0;
    tach_step(1'b0, 1'b1);
    tape_abort_n <= 1'b1;
    check_all();
    // borrow from all-zero, then the up step that wraps back with no carry into the top digit
    hw_clear();
    tach_step(1'b1, 1'b0);
    axi_read(REG_STATUS, rd, rsp);
    chk_word(rd & 32'h1, 32'h0);
    check_all();
    tach_step(1'b1, 1'b1);
    check_all();
    repeat (8) begin
      tach_step(1'b1, rnd() % 32'd2 == 32'd1);
      check_all();
    end
    wstrb <= 4'he;
    axi_write(REG_CTRL, 32'h1, rsp);
    axi_read(REG_CTRL, rd, rsp);
    chk_word(rd, 32'h0);
    wstrb <= 4'hf;
    axi_write(REG_CTRL, 32'h1, rsp);
    axi_read(REG_CTRL, rd, rsp);
    chk_word(rd, 32'h1);
    axi_read(REG_STATUS, rd, rsp);
    chk_word(rd & 32'h8, 32'h8);
    tach_step(1'b0, 1'b1);
    axi_write(REG_CTRL, 32'h0, rsp);
    wait_cycles(10);
    digs = '{default: 0};
    check_all();
    give_verdict();
  end
endmodule : tape_elapsed_time_updown_counter_test

// [rtl/tach_sync.sv]
// tachometer synchroniser making one clock pulse per tach pulse
`timescale 1ns/1ns
module tach_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tach_in,
  output logic tach_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // two stage sync then edge history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= tach_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // rising edge only, whatever the pulse length
  assign tach_pulse = sync_reg & ~prev_reg;
endmodule : tach_sync

// [rtl/tape_timer.sv]
// digit-serial up/down elapsed tape time counter, top level
`timescale 1ns/1ns
module tape_timer
  import tape_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tach_pulse_in,
  input wire logic tape_direction_command,
  input wire logic speed_select_lo,
  input wire logic speed_select_hi,
  input wire logic timer_clear_n,
  input wire logic tape_abort_n,
  output logic [3:0] digit_out,
  output logic [7:0] slot_out,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  timer_status_if stat_if ();

  slot_t slot_reg;
  slot_t slot_next;
  logic [3:0] digit_reg [NUM_DIGITS];
  logic [3:0] wake_cnt_reg;
  logic up_reg;
  logic carry_reg;
  logic carry_next;
  logic tach_held_reg;
  logic tach_held_next;
  logic [27:0] shadow_reg;
  logic [31:0] count_reg;

  logic tach_pulse;
  logic wake_active;
  logic clear_act;
  logic is_t7;
  logic [1:0] speed;
  logic [3:0] cur_digit;
  logic [3:0] mod_val;
  logic [3:0] mod_comp;
  logic [3:0] detect_b;
  logic [3:0] sub_a;
  logic [3:0] sub_b;
  logic [3:0] add_b;
  logic add_cin;
  logic carry_eff;
  logic [3:0] sum_digit;
  logic [3:0] detect_sum;
  logic boundary_hit;
  logic [3:0] sub_out;
  logic [3:0] new_digit;

  ////////////////////////////////////////////////////////////////////
  // submodules

  // tach input retimed to a single clock pulse
  tach_sync u_tach_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .tach_in(tach_pulse_in),
    .tach_pulse(tach_pulse)
  );

  // software access to control, status and count
  timer_axil_regs u_regs (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .stat(stat_if.regs)
  );

  ////////////////////////////////////////////////////////////////////
  // clear sources and ring counter

  // pushbutton, wake-up and software clear share one path
  assign wake_active = wake_cnt_reg != 4'h0;
  assign clear_act = ~timer_clear_n | wake_active | stat_if.soft_clear;

  // wake-up clear held for one full digit cycle after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg <= WAKE_CLEAR_CYCLES;
    end else if (wake_active) begin
      wake_cnt_reg <= wake_cnt_reg - 4'h1;
    end
  end

  // one-hot ring, t7 wraps back to t0
  always_comb begin
    unique case (slot_reg)
      SLOT_T0: slot_next = SLOT_T1;
      SLOT_T1: slot_next = SLOT_T2;
      SLOT_T2: slot_next = SLOT_T3;
      SLOT_T3: slot_next = SLOT_T4;
      SLOT_T4: slot_next = SLOT_T5;
      SLOT_T5: slot_next = SLOT_T6;
      SLOT_T6: slot_next = SLOT_T7;
      SLOT_T7: slot_next = SLOT_T0;
      default: slot_next = SLOT_T0;
    endcase
  end

  // ring register and direction latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= SLOT_T0;
      up_reg <= 1'b1;
    end else begin
      slot_reg <= slot_next;
      up_reg <= tape_direction_command;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // modulo logic and complementary encoder

  assign is_t7 = slot_reg == SLOT_T7;
  assign speed = {speed_select_hi, speed_select_lo};
  assign cur_digit = digit_reg[0];

  // per-slot modulus and its fifteens complement
  assign mod_val = digit_modulus(slot_reg, speed);
  assign mod_comp = ~mod_val;

  // up: complement to detector; down: modulus to subtractor
  assign detect_b = up_reg ? mod_comp : DIGIT_ZERO;
  assign sub_a = up_reg ? DIGIT_ZERO : mod_val;
  assign sub_b = up_reg ? DIGIT_ZERO : DIGIT_ALL_ONES;

  ////////////////////////////////////////////////////////////////////
  // adder, boundary detector and ones subtractor

  // carry output gated by t7, abort and clear
  assign carry_eff = carry_reg & ~is_t7 & tape_abort_n & ~clear_act;

  // up: carry into cin; down: carry onto all b inputs
  assign add_b = up_reg ? DIGIT_ZERO : {4{carry_eff}};
  assign add_cin = up_reg & carry_eff;
  assign sum_digit = 4'(cur_digit + add_b + {3'b000, add_cin});

  // match when sum plus detector operand reaches fifteen
  assign detect_sum = 4'(sum_digit + detect_b);
  assign boundary_hit = detect_sum == DIGIT_ALL_ONES;
  assign sub_out = 4'(sub_a + sub_b);

  // subtractor result replaces the sum on a boundary
  assign new_digit = clear_act ? DIGIT_ZERO :
                     boundary_hit ? sub_out : sum_digit;

  ////////////////////////////////////////////////////////////////////
  // carry flip-flop and tach pulse latch

  // t7 end loads the held tach, other slots the boundary carry
  assign carry_next = clear_act ? 1'b0 :
                      is_t7 ? tach_held_reg : boundary_hit;

  // new pulse wins over the transfer clear
  assign tach_held_next = clear_act ? 1'b0 :
                          tach_pulse | (tach_held_reg & ~is_t7);

  // carry and tach latch registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      carry_reg <= 1'b0;
      tach_held_reg <= 1'b0;
    end else begin
      carry_reg <= carry_next;
      tach_held_reg <= tach_held_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // recirculating digit shift register

  // one nibble per clock, result written at the tail
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DIGITS; i++) begin
        digit_reg[i] <= DIGIT_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_DIGITS - 1; i++) begin
        digit_reg[i] <= clear_act ? DIGIT_ZERO : digit_reg[i + 1];
      end
      digit_reg[NUM_DIGITS - 1] <= new_digit;
    end
  end

  // whole count captured at each t7 for software reads
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= 28'h0000000;
      count_reg <= 32'h00000000;
    end else begin
      shadow_reg <= {new_digit, shadow_reg[27:4]};
      if (is_t7) begin
        count_reg <= {new_digit, shadow_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs and status

  // display data straight from the register head
  assign digit_out = digit_reg[0];
  assign slot_out = slot_reg;
  assign stat_if.count_up = up_reg;
  assign stat_if.carry = carry_reg;
  assign stat_if.tach_pending = tach_held_reg;
  assign stat_if.clearing = clear_act;
  assign stat_if.slot = slot_reg;
  assign stat_if.count = count_reg;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_tach_at_t7;
    is_t7 && tach_held_reg && !clear_act;
  endsequence

  sequence s_carry_at_t0;
    carry_reg && slot_reg == SLOT_T0;
  endsequence

  property p_tach_to_carry;
    s_tach_at_t7 |=> s_carry_at_t0;
  endproperty

  chk_ring_wrap: assert property (is_t7 |=> slot_reg == SLOT_T0 ##7 is_t7)
    else $error("ring did not complete eight slots");

  chk_ring_onehot: assert property ($onehot(slot_reg))
    else $error("ring not one-hot");

  chk_dir_latch: assert property (##1 up_reg == $past(tape_direction_command))
    else $error("direction latch missed command");

  chk_idle_recirc: assert property (!carry_eff && !clear_act |-> new_digit == cur_digit)
    else $error("digit altered without carry");

  chk_up_step: assert property (up_reg && carry_eff && !boundary_hit
    |-> new_digit == 4'(cur_digit + DIGIT_ONE))
    else $error("count up did not add one");

  chk_down_step: assert property (!up_reg && carry_eff && !boundary_hit
    |-> new_digit == 4'(cur_digit - DIGIT_ONE))
    else $error("count down did not subtract one");

  chk_up_wrap_zero: assert property (up_reg && boundary_hit && !clear_act
    |-> new_digit == DIGIT_ZERO ##1 carry_reg)
    else $error("count up boundary wrong");

  chk_down_wrap: assert property (!up_reg && boundary_hit && !clear_act
    |-> new_digit == 4'(mod_val - DIGIT_ONE) ##1 carry_reg)
    else $error("count down borrow wrong");

  chk_tach_carry: assert property (p_tach_to_carry)
    else $error("held tach not moved to carry");

  chk_t7_gate: assert property ((is_t7 || !tape_abort_n) && !clear_act
    |-> !carry_eff && new_digit == cur_digit)
    else $error("carry not gated");

  chk_clear_zero: assert property (clear_act [*8] |=> digit_reg[0] == DIGIT_ZERO)
    else $error("clear left a nonzero digit");

  chk_t0_comp: assert property (slot_reg == SLOT_T0 && up_reg && speed == SPEED_30
    |-> detect_b == 4'h7)
    else $error("t0 complement wrong");

endmodule : tape_timer

// [rtl/tape_timer_pkg.sv]
// constants, types and decode helpers for the tape elapsed time counter
package tape_timer_pkg;
  localparam int NUM_DIGITS = 8;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam logic [3:0] DIGIT_ALL_ONES = 4'hf;
  localparam logic [3:0] MOD_DECADE = 4'ha;
  localparam logic [3:0] MOD_SEXT = 4'h6;
  localparam logic [3:0] MOD_SPD_30 = 4'h8;
  localparam logic [3:0] MOD_SPD_15 = 4'h4;
  localparam logic [3:0] MOD_SPD_7P5 = 4'h2;
  localparam logic [3:0] MOD_SPD_3P75 = 4'h1;
  localparam logic [1:0] SPEED_30 = 2'h0;
  localparam logic [1:0] SPEED_15 = 2'h1;
  localparam logic [1:0] SPEED_7P5 = 2'h2;
  localparam logic [3:0] WAKE_CLEAR_CYCLES = 4'h8;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_SOFT_CLEAR = 0;

  typedef enum logic [7:0] {
    SLOT_T0 = 8'h01, SLOT_T1 = 8'h02, SLOT_T2 = 8'h04, SLOT_T3 = 8'h08,
    SLOT_T4 = 8'h10, SLOT_T5 = 8'h20, SLOT_T6 = 8'h40, SLOT_T7 = 8'h80
  } slot_t;

  // modulus of the digit in each slot, t0 set by tape speed
  function automatic logic [3:0] digit_modulus(input slot_t slot, input logic [1:0] speed);
    logic [3:0] m;
    m = MOD_DECADE;
    if (slot == SLOT_T0) begin
      m = (speed == SPEED_30) ? MOD_SPD_30 :
          (speed == SPEED_15) ? MOD_SPD_15 :
          (speed == SPEED_7P5) ? MOD_SPD_7P5 : MOD_SPD_3P75;
    end else if (slot == SLOT_T3 || slot == SLOT_T5) begin
      m = MOD_SEXT;
    end
    return m;
  endfunction : digit_modulus

  // register map decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] addr);
    return addr == REG_CTRL || addr == REG_STATUS || addr == REG_COUNT;
  endfunction : addr_mapped
endpackage : tape_timer_pkg

// [rtl/timer_axil_regs.sv]
// axi4-lite slave for control, status and count snapshot
`timescale 1ns/1ns
module timer_axil_regs
  import tape_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  timer_status_if.regs stat
);
  logic aw_held_reg, w_held_reg, strb0_reg, soft_clear_reg;
  logic [7:0] awaddr_reg;
  logic wbit_reg;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic do_write;

  // handshake and read decode
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign status_word = {16'h0000, stat.slot, 4'h0, stat.clearing, stat.tach_pending,
                        stat.carry, stat.count_up};
  assign read_word = (s_axi_araddr == REG_CTRL) ? {31'h00000000, soft_clear_reg} :
                     (s_axi_araddr == REG_STATUS) ? status_word :
                     (s_axi_araddr == REG_COUNT) ? stat.count : 32'h00000000;
  assign stat.soft_clear = soft_clear_reg;

  // write channels taken in either order, response after both
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wbit_reg <= 1'b0;
      strb0_reg <= 1'b0;
      soft_clear_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wbit_reg <= s_axi_wdata[CTRL_SOFT_CLEAR];
        strb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_reg == REG_CTRL && strb0_reg) begin
          soft_clear_reg <= wbit_reg;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read answer one clock after the address is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : timer_axil_regs

// [rtl/timer_status_if.sv]
// status and control carried between counter core and register slave
`timescale 1ns/1ns
interface timer_status_if;
  logic soft_clear;
  logic count_up;
  logic carry;
  logic tach_pending;
  logic clearing;
  logic [7:0] slot;
  logic [31:0] count;
  modport regs (output soft_clear, input count_up, carry, tach_pending, clearing, slot, count);
  modport core (input soft_clear, output count_up, carry, tach_pending, clearing, slot, count);
endinterface : timer_status_if
